// ===== design/ias_regs.svh
// register offsets, field positions, reset values and state counts
// assumes: included by bare name from the top module only; the package does not include it
`ifndef IAS_REGS_SVH
`define IAS_REGS_SVH

// ----------------------------------------------------------------------
// register byte offsets (apb, one aligned word each)
// ----------------------------------------------------------------------
`define IAS_OFS_CTRL      8'h00
`define IAS_OFS_CHSEL     8'h04
`define IAS_OFS_PRIO_LO   8'h08
`define IAS_OFS_PRIO_HI   8'h0C
`define IAS_OFS_MASK      8'h10
`define IAS_OFS_STATUS    8'h14

// ----------------------------------------------------------------------
// field positions and widths
// ----------------------------------------------------------------------
`define IAS_CTRL_GEN_BIT  0
`define IAS_CTRL_CHEN_LSB 4
`define IAS_NUM_CH        4
`define IAS_SEL_W         4
`define IAS_PRIO_W        4
`define IAS_STAT_SRC_LSB  16
`define IAS_STAT_BUSY_BIT 20

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define IAS_RST_CTRL      32'h0000_0000
`define IAS_RST_CHSEL     32'h0000_0000
`define IAS_RST_PRIO      32'h0000_0000
`define IAS_RST_MASK      4'hF

// ----------------------------------------------------------------------
// response timing, in states (one state = one pclk cycle)
// ----------------------------------------------------------------------
`define IAS_JUDGE_ST      3'h1
`define IAS_CMP_ST_INT    3'h2
`define IAS_CMP_ST_IRQ    3'h3
`define IAS_PRE_ST        3'h2
`define IAS_MID_ST        3'h1
`define IAS_POST_ST       3'h2

`endif

// ===== design/ias_pkg.sv
// types shared by the routing and response block
// assumes: compiled before the top module that uses its types; it does not include the constants header
package ias_pkg;

    // ------------------------------------------------------------------
    // exception bus accesses issued on behalf of the cpu
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        IAS_ACC_SR_WR,
        IAS_ACC_PC_WR,
        IAS_ACC_VEC_RD
    } ias_acc_t;

    typedef struct packed {
        logic       valid;
        ias_acc_t   kind;
        logic [7:0] vec;
    } ias_exc_req_t;

    // apb answer carried as one group
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } ias_apb_rsp_t;

endpackage

// ===== design/ias_top.sv
// interrupt routing between cpu and dma, arbitration and response sequencing
// assumes: one pclk domain, apb master on the same clock, on-chip sources
// synchronous to pclk, external irq pins asynchronous and active low
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "ias_regs.svh"

module ias_top #(
    parameter int         NINT     = 8,
    parameter int         NIRQ     = 4,
    parameter logic [7:0] VEC_BASE = 8'h40,
    parameter logic [7:0] DMA_CAP  = 8'hFF
) (
    // clock, reset, enable
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         ce,
    // apb slave
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [7:0]                   paddr,
    input  wire logic [31:0]                  pwdata,
    output ias_pkg::ias_apb_rsp_t             apb_rsp,
    // request sources
    input  wire logic [NINT-1:0]              src_req,
    input  wire logic [NIRQ-1:0]              irq_pin_n,
    // dma side
    output logic [NINT-1:0]                   dma_trig,
    // cpu side
    input  wire logic                         cpu_seq_done,
    output logic                              cpu_irq,
    output logic [3:0]                        cpu_mask_level,
    output ias_pkg::ias_exc_req_t             exc_req,
    input  wire logic                         exc_ack,
    input  wire logic [31:0]                  exc_rdata,
    output logic                              fetch_start,
    output logic [31:0]                       fetch_addr
);
    localparam int NSRC = NINT + NIRQ;

    // ------------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------------
    logic [NIRQ-1:0] irq_s1;
    logic [NIRQ-1:0] irq_s2;

    // only irq_s2 is read by logic; irq_s1 feeds nothing else
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_s1 <= '1;
            irq_s2 <= '1;
        end else if (ce) begin
            irq_s1 <= irq_pin_n;
            irq_s2 <= irq_s1;
        end
    end

    // ------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------
    logic [31:0]     ctrl;
    logic [31:0]     chsel;
    logic [31:0]     prio_lo;
    logic [31:0]     prio_hi;
    logic [31:0]     next_ctrl;
    logic [31:0]     next_chsel;
    logic [31:0]     next_prio_lo;
    logic [31:0]     next_prio_hi;
    logic [3:0]      next_mask_level;
    ias_pkg::ias_apb_rsp_t next_rsp;
    logic            wr_en;
    logic            setup;
    logic [31:0]     status;
    logic            hw_mask_load;
    logic [3:0]      hw_mask_value;

    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pwrite & apb_rsp.pready;

    // writes land on the completing edge; hardware mask load beats software
    always_comb begin
        next_ctrl       = ctrl;
        next_chsel      = chsel;
        next_prio_lo    = prio_lo;
        next_prio_hi    = prio_hi;
        next_mask_level = cpu_mask_level;
        if (wr_en) begin
            case (paddr)
                `IAS_OFS_CTRL:    next_ctrl = pwdata;
                `IAS_OFS_CHSEL:   next_chsel = pwdata;
                `IAS_OFS_PRIO_LO: next_prio_lo = pwdata;
                `IAS_OFS_PRIO_HI: next_prio_hi = pwdata;
                `IAS_OFS_MASK:    next_mask_level = pwdata[3:0];
                default:          next_ctrl = ctrl;
            endcase
        end
        if (hw_mask_load) begin
            next_mask_level = hw_mask_value;
        end
    end

    // answer is prepared in the setup cycle so pready comes from a flop
    always_comb begin
        next_rsp = '0;
        if (setup) begin
            next_rsp.pready = 1'b1;
            case (paddr)
                `IAS_OFS_CTRL:    next_rsp.prdata = ctrl;
                `IAS_OFS_CHSEL:   next_rsp.prdata = chsel;
                `IAS_OFS_PRIO_LO: next_rsp.prdata = prio_lo;
                `IAS_OFS_PRIO_HI: next_rsp.prdata = prio_hi;
                `IAS_OFS_MASK:    next_rsp.prdata = {28'h0000000, cpu_mask_level};
                `IAS_OFS_STATUS:  next_rsp.prdata = status;
                default:          next_rsp.pslverr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl           <= `IAS_RST_CTRL;
            chsel          <= `IAS_RST_CHSEL;
            prio_lo        <= `IAS_RST_PRIO;
            prio_hi        <= `IAS_RST_PRIO;
            cpu_mask_level <= `IAS_RST_MASK;
            apb_rsp        <= '0;
        end else if (ce) begin
            ctrl           <= next_ctrl;
            chsel          <= next_chsel;
            prio_lo        <= next_prio_lo;
            prio_hi        <= next_prio_hi;
            cpu_mask_level <= next_mask_level;
            apb_rsp        <= next_rsp;
        end
    end

    // ------------------------------------------------------------------
    // dma masking and arbitration, all combinational
    // ------------------------------------------------------------------
    logic                  dma_global_enable;
    logic [3:0]            dma_ch_en;
    logic [NSRC-1:0]       src_all;
    logic [NSRC-1:0]       dma_owned;
    logic [NSRC-1:0]       cpu_view;
    logic [NSRC*4-1:0]     prio_flat;
    logic [3:0]            best_prio;
    logic [3:0]            best_idx;
    logic                  found;

    assign dma_global_enable = ctrl[`IAS_CTRL_GEN_BIT];
    assign dma_ch_en         = ctrl[`IAS_CTRL_CHEN_LSB +: `IAS_NUM_CH];
    assign src_all           = {~irq_s2, src_req};
    assign prio_flat         = (NSRC*4)'({prio_hi, prio_lo}); // upper nibbles unused

    // settings changes act on the very next arbitration
    always_comb begin
        dma_owned = '0;
        for (int i = 0; i < NINT; i++) begin
            for (int c = 0; c < `IAS_NUM_CH; c++) begin
                if (dma_ch_en[c] && chsel[c*`IAS_SEL_W +: `IAS_SEL_W] == 4'(i)) begin
                    dma_owned[i] = dma_global_enable;
                end
            end
        end
    end

    // unowned sources stay visible to the cpu side
    assign cpu_view = src_all & ~dma_owned;

    // strict compare against mask; lowest index wins a tie
    always_comb begin
        best_prio = cpu_mask_level;
        best_idx  = 4'h0;
        found     = 1'b0;
        for (int i = 0; i < NSRC; i++) begin
            if (cpu_view[i] && prio_flat[i*4 +: 4] > best_prio) begin
                best_prio = prio_flat[i*4 +: 4];
                best_idx  = 4'(i);
                found     = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // response sequencer
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        S_IDLE, S_JUDGE, S_CMP, S_WAIT, S_PRE, S_SR, S_PC, S_MID, S_VEC, S_POST
    } ias_state_t;

    ias_state_t            state;
    ias_state_t            next_state;
    logic [2:0]            cnt;
    logic [2:0]            next_cnt;
    logic [3:0]            cur_src;
    logic [3:0]            next_cur_src;
    logic [3:0]            cur_prio;
    logic [3:0]            next_cur_prio;
    logic [31:0]           next_fetch_addr;
    logic                  next_fetch_start;
    logic                  next_cpu_irq;
    ias_pkg::ias_exc_req_t next_exc_req;
    logic [NINT-1:0]       next_dma_trig;
    logic                  is_irq;

    assign is_irq        = cur_src >= 4'(NINT);
    assign hw_mask_load  = (state == S_PC) && exc_ack;
    assign hw_mask_value = cur_prio;
    assign status        = {11'h000, state != S_IDLE, cur_src, 4'h0, 12'(cpu_view)};

    always_comb begin
        next_state       = state;
        next_cnt         = cnt;
        next_cur_src     = cur_src;
        next_cur_prio    = cur_prio;
        next_fetch_addr  = fetch_addr;
        next_fetch_start = 1'b0;
        case (state)
            S_IDLE: begin
                if (found) begin
                    next_cur_src  = best_idx;
                    next_cur_prio = best_prio;
                    next_cnt      = 3'h1;
                    // extra state only where the dma could have claimed it
                    if (best_idx < 4'(NINT) && DMA_CAP[best_idx[2:0]]) begin
                        next_state = S_JUDGE;
                    end else begin
                        next_state = S_CMP;
                    end
                end
            end
            S_JUDGE: begin
                next_state = S_CMP;
                next_cnt   = 3'h1;
            end
            S_CMP: begin
                // irq compare takes one state more
                if (cnt < (is_irq ? `IAS_CMP_ST_IRQ : `IAS_CMP_ST_INT)) begin
                    next_cnt = cnt + 3'h1;
                end else if (!cpu_view[cur_src]) begin
                    next_state = S_IDLE; // withdrawn or claimed meanwhile
                end else begin
                    next_cnt   = 3'h1;
                    next_state = cpu_seq_done ? S_PRE : S_WAIT;
                end
            end
            S_WAIT: begin
                if (cpu_seq_done) begin
                    next_state = S_PRE;
                    next_cnt   = 3'h1;
                end
            end
            S_PRE: begin
                if (cnt < `IAS_PRE_ST) begin
                    next_cnt = cnt + 3'h1;
                end else begin
                    next_state = S_SR;
                end
            end
            S_SR: begin
                if (exc_ack) begin
                    next_state = S_PC;
                end
            end
            S_PC: begin
                if (exc_ack) begin
                    next_state = S_MID;
                    next_cnt   = 3'h1;
                end
            end
            S_MID: begin
                if (cnt < `IAS_MID_ST) begin
                    next_cnt = cnt + 3'h1;
                end else begin
                    next_state = S_VEC;
                end
            end
            S_VEC: begin
                if (exc_ack) begin
                    next_fetch_addr = exc_rdata;
                    next_state      = S_POST;
                    next_cnt        = 3'h1;
                end
            end
            S_POST: begin
                if (cnt < `IAS_POST_ST) begin
                    next_cnt = cnt + 3'h1;
                end else begin
                    next_fetch_start = 1'b1;
                    next_state       = S_IDLE;
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
    end

    // exception and irq outputs decoded from the next state, dma_trig from the sources, so they leave from flops
    always_comb begin
        next_exc_req       = '0;
        next_exc_req.vec   = VEC_BASE + 8'(next_cur_src);
        next_cpu_irq       = !(next_state inside {S_IDLE, S_JUDGE, S_CMP});
        case (next_state)
            S_SR: begin
                next_exc_req.valid = 1'b1;
                next_exc_req.kind  = ias_pkg::IAS_ACC_SR_WR;
            end
            S_PC: begin
                next_exc_req.valid = 1'b1;
                next_exc_req.kind  = ias_pkg::IAS_ACC_PC_WR;
            end
            S_VEC: begin
                next_exc_req.valid = 1'b1;
                next_exc_req.kind  = ias_pkg::IAS_ACC_VEC_RD;
            end
            default: begin
                next_exc_req.valid = 1'b0;
            end
        endcase
        // dma sees only what it owns; it clears the source itself
        next_dma_trig = src_req & dma_owned[NINT-1:0];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state       <= S_IDLE;
            cnt         <= 3'h0;
            cur_src     <= 4'h0;
            cur_prio    <= 4'h0;
            fetch_addr  <= 32'h0000_0000;
            fetch_start <= 1'b0;
            cpu_irq     <= 1'b0;
            exc_req     <= '0;
            dma_trig    <= '0;
        end else if (ce) begin
            state       <= next_state;
            cnt         <= next_cnt;
            cur_src     <= next_cur_src;
            cur_prio    <= next_cur_prio;
            fetch_addr  <= next_fetch_addr;
            fetch_start <= next_fetch_start;
            cpu_irq     <= next_cpu_irq;
            exc_req     <= next_exc_req;
            dma_trig    <= next_dma_trig;
        end
    end

endmodule

// ===== verif/ias_cpu_model.sv
// far-side model: cpu exception bus, sequence-end flag and dma source clearing
// assumes: same pclk as the block, ack may come in the cycle the request shows
`timescale 1ns/1ps

module ias_cpu_model #(
    parameter int         NSRC     = 12,
    parameter int         NINT     = 8,
    parameter logic [7:0] VEC_BASE = 8'h40
) (
    // clock, reset, pacing
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            slow,
    // exception bus
    input  ias_pkg::ias_exc_req_t exc_req,
    output logic                 exc_ack,
    output logic [31:0]          exc_rdata,
    output logic                 cpu_seq_done,
    // fetch and dma side
    input  wire logic            fetch_start,
    input  wire logic [31:0]     fetch_addr,
    input  wire logic [NINT-1:0] dma_trig,
    output logic [NSRC-1:0]      clr
);
    // --------------------------------------------------------------
    // pacing and answers
    // --------------------------------------------------------------
    logic [7:0] cnt;
    logic       go;

    // free counter paces slow mode and scrambles idle read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 8'h00;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end

    // slow mode answers only every fourth cycle
    assign go           = !slow || cnt[1:0] == 2'h3;
    assign cpu_seq_done = go;
    assign exc_ack      = exc_req.valid && go;
    // vector data names its source; idle data never repeats the last value
    assign exc_rdata = (exc_req.valid && exc_req.kind == ias_pkg::IAS_ACC_VEC_RD) ?
                       32'h0000_1000 + 32'(exc_req.vec) : {4{~cnt}};

    // routine clears its own source, dma clears a trigger while moving data
    always_comb begin
        clr = NSRC'(dma_trig);
        if (fetch_start) begin
            clr = clr | (NSRC'(1) << (fetch_addr - 32'h1000 - 32'(VEC_BASE)));
        end
    end
endmodule

// ===== verif/ias_monitor.sv
// concurrent checks on the routing block's cpu and dma ports
// assumes: bound onto ias_top, single pclk domain
`timescale 1ns/1ps

module ias_monitor #(
    parameter int         NINT     = 8,
    parameter logic [7:0] VEC_BASE = 8'h40
) (
    // clock and reset
    input wire logic                  pclk,
    input wire logic                  presetn,
    // sources and dma
    input wire logic [NINT-1:0]       src_req,
    input wire logic [NINT-1:0]       dma_trig,
    // cpu side
    input wire logic                  cpu_irq,
    input wire logic [3:0]            cpu_mask_level,
    input ias_pkg::ias_exc_req_t      exc_req,
    input wire logic                  exc_ack,
    input wire logic [31:0]           exc_rdata,
    input wire logic                  fetch_start,
    input wire logic [31:0]           fetch_addr
);
    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    logic        hs;
    logic [31:0] vec_q;
    logic [15:0] trig_w;

    assign hs     = exc_req.valid && exc_ack;
    assign trig_w = 16'(dma_trig);

    // vector word kept so the fetch address can be tied to it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vec_q <= 32'h0000_0000;
        end else if (hs && exc_req.kind == ias_pkg::IAS_ACC_VEC_RD) begin
            vec_q <= exc_rdata;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_EXC_HOLD: assert property (exc_req.valid && !exc_ack |=>
        exc_req.valid && $stable(exc_req)) else $error("exception request dropped");
    AST_SR_PC: assert property (hs && exc_req.kind == ias_pkg::IAS_ACC_SR_WR |->
        ##[1:60] (exc_req.valid && exc_req.kind == ias_pkg::IAS_ACC_PC_WR))
        else $error("pc save missing after sr save");
    AST_PC_VEC: assert property (hs && exc_req.kind == ias_pkg::IAS_ACC_PC_WR |->
        ##[2:60] (exc_req.valid && exc_req.kind == ias_pkg::IAS_ACC_VEC_RD))
        else $error("vector read missing after pc save");
    AST_VEC_FETCH: assert property (hs && exc_req.kind == ias_pkg::IAS_ACC_VEC_RD |->
        ##[1:4] fetch_start) else $error("fetch late after vector read");
    AST_FETCH_ADDR: assert property (fetch_start |->
        fetch_addr == vec_q && !$past(fetch_start)) else $error("fetch address or pulse wrong");
    AST_IRQ_SPAN: assert property (exc_req.valid |-> cpu_irq)
        else $error("exception access without accepted interrupt");
    AST_IRQ_REQ: assert property ($rose(cpu_irq) |-> ##[1:60] exc_req.valid)
        else $error("accepted interrupt never starts exception");
    AST_TRIG_SRC: assert property ((dma_trig & ~$past(src_req)) == '0)
        else $error("dma trigger without source");
    AST_DMA_NOT_CPU: assert property (exc_req.valid |->
        trig_w[4'(exc_req.vec - VEC_BASE)] == 1'b0) else $error("dma source taken by cpu");
    AST_MASK_RISE: assert property (hs && exc_req.kind == ias_pkg::IAS_ACC_PC_WR |=>
        cpu_mask_level > $past(cpu_mask_level)) else $error("mask not raised");
endmodule

bind ias_top ias_monitor #(.NINT(NINT), .VEC_BASE(VEC_BASE)) u_mon (
    .pclk(pclk), .presetn(presetn), .src_req(src_req), .dma_trig(dma_trig),
    .cpu_irq(cpu_irq), .cpu_mask_level(cpu_mask_level), .exc_req(exc_req),
    .exc_ack(exc_ack), .exc_rdata(exc_rdata), .fetch_start(fetch_start),
    .fetch_addr(fetch_addr));

// ===== verif/irq_dma_routing_and_response_tb.sv
// self-checking bench for the routing and response block
// assumes: design package and top in design/, model and checker in verif/
`timescale 1ns/1ps

module irq_dma_routing_and_response_tb;
    // --------------------------------------------------------------
    // setup
    // --------------------------------------------------------------
    localparam int         NINT = 8;
    localparam int         NIRQ = 4;
    localparam logic [7:0] VB   = 8'h40;
    localparam logic [7:0] CAP  = 8'h0F; // sources 4..7 skip the judge state
    localparam int         LAT  = 12;    // 10 states, plus capture and sampling edges

    logic                  pclk, presetn, psel, penable, pwrite, slow, err;
    logic [7:0]            paddr;
    logic [31:0]           pwdata, exc_rdata, fetch_addr, rd;
    logic [NINT-1:0]       src_req, dma_trig;
    logic [NIRQ-1:0]       irq_pin_n;
    logic                  cpu_seq_done, cpu_irq, exc_ack, fetch_start, seen, irqs;
    logic [3:0]            cpu_mask_level;
    logic [NINT+NIRQ-1:0]  clr;
    ias_pkg::ias_apb_rsp_t apb_rsp;
    ias_pkg::ias_exc_req_t exc_req;
    int                    n_mismatch = 0;
    int                    n_tests = 0;
    int                    idx;
    int                    corner[3] = '{0, 4, 8};
    integer                seed = 32'h7565;

    ias_top #(.NINT(NINT), .NIRQ(NIRQ), .VEC_BASE(VB), .DMA_CAP(CAP)) dut (
        .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .apb_rsp(apb_rsp),
        .src_req(src_req), .irq_pin_n(irq_pin_n), .dma_trig(dma_trig),
        .cpu_seq_done(cpu_seq_done), .cpu_irq(cpu_irq), .cpu_mask_level(cpu_mask_level),
        .exc_req(exc_req), .exc_ack(exc_ack), .exc_rdata(exc_rdata),
        .fetch_start(fetch_start), .fetch_addr(fetch_addr));

    ias_cpu_model #(.NSRC(NINT + NIRQ), .NINT(NINT), .VEC_BASE(VB)) u_cpu (
        .pclk(pclk), .presetn(presetn), .slow(slow), .exc_req(exc_req),
        .exc_ack(exc_ack), .exc_rdata(exc_rdata), .cpu_seq_done(cpu_seq_done),
        .fetch_start(fetch_start), .fetch_addr(fetch_addr), .dma_trig(dma_trig),
        .clr(clr));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // sources stay up until the cpu routine or the dma clears them
    always @(posedge pclk) begin
        if (|clr) begin
            src_req   <= src_req & ~clr[NINT-1:0];
            irq_pin_n <= irq_pin_n | clr[NINT+NIRQ-1:NINT];
        end
    end

    // --------------------------------------------------------------
    // tasks
    // --------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen_v, input logic [31:0] exp);
        n_tests++;
        if (seen_v !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen_v);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 50);
        chk("pready", {31'h0, apb_rsp.pready}, 32'h1);
        rd      = apb_rsp.prdata;
        err     = apb_rsp.pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic raise(input int i);
        @(posedge pclk);
        if (i < NINT) begin
            src_req[i] <= 1'b1;
        end else begin
            irq_pin_n[i-NINT] <= 1'b0;
        end
    endtask

    // exp of zero skips the latency figure (slow partner or late unmask)
    task automatic wait_fetch(input int i, input int exp);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (fetch_start !== 1'b1 && n < 400);
        if (exp > 0) chk("latency", 32'(n), 32'(exp));
        chk("fetch_addr", fetch_addr, 32'h1000 + 32'(VB) + 32'(i));
        chk("mask_level", 32'(cpu_mask_level), 32'(i + 1));
        apb(1'b1, 8'h10, 32'h0);
    endtask

    function automatic int exp_lat(input int i);
        return (i >= NINT) ? LAT + 3 : LAT + int'(CAP[i]);
    endfunction

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // hang guard, far above the few hundred cycles the sequence needs
    initial begin
        #2_000_000;
        n_mismatch++;
        give_verdict();
    end

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        src_req = '0;
        irq_pin_n = '1;
        slow = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        chk("ctrl_rst", rd, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk("mask_rst", rd, 32'hF);
        apb(1'b0, 8'h18, 32'h0);
        chk("slverr", {31'h0, err}, 32'h1);
        apb(1'b1, 8'h08, 32'h8765_4321);
        apb(1'b1, 8'h0C, 32'h0000_CBA9);
        apb(1'b1, 8'h10, 32'h0);
        apb(1'b0, 8'h0C, 32'h0);
        chk("prio_hi", rd, 32'h0000_CBA9);
        apb(1'b0, 8'h14, 32'h0);
        chk("status_idle", rd, 32'h0);
        // dma-capable, plain peripheral and external pin, fastest partner
        foreach (corner[k]) begin
            raise(corner[k]);
            wait_fetch(corner[k], exp_lat(corner[k]));
        end
        // equal priority is ignored, one level lower lets it through
        apb(1'b1, 8'h10, 32'h6);
        raise(5);
        repeat (30) @(posedge pclk);
        chk("irq_at_mask", {31'h0, cpu_irq}, 32'h0);
        apb(1'b1, 8'h10, 32'h5);
        wait_fetch(5, 0);
        // channel 2 takes source 3 under the global enable
        apb(1'b1, 8'h04, 32'h0000_0300);
        apb(1'b1, 8'h00, 32'h0000_0041);
        raise(3);
        seen = 1'b0;
        irqs = 1'b0;
        repeat (8) begin
            @(posedge pclk);
            seen = seen | dma_trig[3];
            irqs = irqs | cpu_irq;
        end
        chk("dma_trig", {31'h0, seen}, 32'h1);
        chk("cpu_irq", {31'h0, irqs}, 32'h0);
        chk("src_cleared", {31'h0, src_req[3]}, 32'h0);
        // global enable off: same source reaches the cpu at once
        apb(1'b1, 8'h00, 32'h0000_0040);
        raise(3);
        wait_fetch(3, exp_lat(3));
        // random sources with prompt or slow partner
        repeat (24) begin
            idx = int'($unsigned($random(seed)) % 12);
            slow <= 1'($random(seed));
            raise(idx);
            wait_fetch(idx, slow ? 0 : exp_lat(idx));
        end
        give_verdict();
    end
endmodule
